// File: rtl/adwg_pkg.sv
// Constants, field layouts and carrier types of the waveform gain and phase path
package adwg_pkg;
    // ------------------------------------------------------------
    // Conversion limits and timing
    // ------------------------------------------------------------
    localparam int SAMP_W = 20;
    localparam logic [19:0] POS_LIMIT = 20'h40000;
    localparam logic [19:0] NEG_LIMIT = 20'hC0000;
    localparam int MOD_DIV = 4;
    localparam int OUT_DIV = 128;
    localparam int MOD_PER_OUT = OUT_DIV / MOD_DIV;
    localparam logic [7:0] PH_BASE = 8'h62;
    localparam logic [7:0] PH_MIN = 8'h9E;
    localparam logic [7:0] PH_MAX = 8'h5C;
    localparam int LPF_SHIFT = 5;
    localparam int LPF_FRAC = 8;
    localparam int GAIN_ONE = 4096;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_IEN = 8'h04;
    localparam logic [7:0] OFS_ISTAT = 8'h08;
    localparam logic [7:0] OFS_GAIN = 8'h0C;
    localparam logic [7:0] OFS_PHASE = 8'h10;
    localparam logic [7:0] OFS_WAVE_HI = 8'h14;
    localparam logic [7:0] OFS_WAVE_LO = 8'h18;
    localparam logic [7:0] OFS_WAVE_BYTE = 8'h1C;
    localparam logic [7:0] OFS_EN_LO = 8'h20;
    localparam logic [7:0] OFS_EN_HI = 8'h24;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SRC_LSB = 13;
    localparam int RATE_LSB = 11;
    localparam int BIT_SAMPLE = 3;
    localparam int BIT_WRAP = 2;
    localparam logic [3:0] IRQ_BITS = 4'hC;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [3:0] IEN_RST = 4'h0;
    localparam logic [11:0] GAIN_RST = 12'h000;
    localparam logic [7:0] PHASE_RST = 8'h00;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_POWER = 2'b00,
        SRC_BOTH = 2'b01,
        SRC_CH1 = 2'b10,
        SRC_CH2 = 2'b11
    } adwg_src_type;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } adwg_bus_req_type;
    typedef struct packed {
        logic [23:0] ch1;
        logic [23:0] ch2;
    } adwg_raw_type;
endpackage

// File: rtl/adwg_path.sv
// Channel gain, phase delay, wave filter and waveform sampling path
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module adwg_path #(
    parameter int DEPTH = 256
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire adwg_pkg::adwg_bus_req_type bus_req,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire adwg_pkg::adwg_raw_type raw,
    output logic mod_tick,
    output logic irq,
    output logic irq_n
);
    import adwg_pkg::*;

    // ------------------------------------------------------------
    // Saturation
    // ------------------------------------------------------------
    function automatic logic [19:0] sat(input logic [23:0] x);
        logic signed [23:0] s;
        s = $signed(x);
        if (s > $signed({{4{1'b0}}, POS_LIMIT})) begin
            sat = POS_LIMIT;
        end else if (s < $signed({{4{1'b1}}, NEG_LIMIT})) begin
            sat = NEG_LIMIT;
        end else begin
            sat = x[19:0];
        end
    endfunction

    // Byte lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] o,
            input logic [31:0] w, input logic [3:0] be);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[8*i +: 8] = w[8*i +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] mc_q;
    logic [4:0] oc_q;
    logic out_tick, t1_q, t2_q, wrap_ev, take, wave_load, rd_done_q, fill_q;
    logic [1:0] src_q, rate_q;
    logic [3:0] ien_q, istat_q;
    logic [11:0] gain_q;
    logic [19:0] ch1_sat, ch2_sat;
    logic [19:0] ch1_q, ch2_q;
    logic [19:0] dline [DEPTH];
    logic [7:0] wp_q, delay, rd_ptr, phase_q, ph_new, cur_byte;
    logic signed [13:0] gain_f;
    logic signed [33:0] prod;
    logic signed [39:0] pw;
    logic [39:0] inc, energy_q, en_sum, wave_q;
    logic signed [27:0] lpf_q, lpf_x;
    logic [2:0] rc_q, rmask, bidx_q, nbytes;
    logic [31:0] rdata_q, rmux, mode_m, ien_m, gain_m, phase_m;
    logic wr, rd_acc, sample_clr;

    // ------------------------------------------------------------
    // Modulator and output tick dividers
    // ------------------------------------------------------------
    // Modulator tick every MOD_DIV clocks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mc_q <= 2'h0;
        end else begin
            mc_q <= mc_q + 2'h1;
        end
    end
    assign mod_tick = (mc_q == 2'(MOD_DIV - 1));

    // Output tick every MOD_PER_OUT modulator ticks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            oc_q <= 5'h00;
        end else if (mod_tick) begin
            oc_q <= oc_q + 5'h01;
        end
    end
    assign out_tick = mod_tick && (oc_q == 5'(MOD_PER_OUT - 1));

    // Pipeline stage strobes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            t1_q <= 1'b0;
            t2_q <= 1'b0;
        end else begin
            t1_q <= out_tick;
            t2_q <= t1_q;
        end
    end

    // ------------------------------------------------------------
    // Conversion, gain and phase delay
    // ------------------------------------------------------------
    assign ch1_sat = sat(raw.ch1);
    assign ch2_sat = sat(raw.ch2);
    assign gain_f = $signed({{2{gain_q[11]}}, gain_q}) + 14'(GAIN_ONE);
    assign prod = $signed(ch1_sat) * gain_f;

    // Delay line written each modulator tick
    always_ff @(posedge ref_clk) begin
        if (mod_tick) begin
            dline[wp_q] <= ch2_sat;
        end
    end

    // Write pointer, and a flag once every word has been written
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_q <= 8'h00;
            fill_q <= 1'b0;
        end else if (mod_tick) begin
            wp_q <= wp_q + 8'h01;
            fill_q <= fill_q || (wp_q == 8'(DEPTH - 1));
        end
    end

    // Negative phase gives a shorter delay
    assign delay = PH_BASE + phase_q;
    assign rd_ptr = wp_q - delay - 8'h01;

    // Sample registers; unwritten taps read zero so energy and filter start clean
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch1_q <= 20'h00000;
            ch2_q <= 20'h00000;
        end else if (out_tick) begin
            ch1_q <= prod[31:12];
            ch2_q <= (fill_q || wp_q > delay) ? dline[rd_ptr] : 20'h00000;
        end
    end

    // ------------------------------------------------------------
    // Power and energy, always running
    // ------------------------------------------------------------
    assign pw = $signed(ch1_q) * $signed(ch2_q);
    assign inc = {{16{pw[39]}}, pw[39:16]};
    assign en_sum = energy_q + inc;
    assign wrap_ev = t1_q && (energy_q[39] == inc[39]) && (en_sum[39] != inc[39]);

    // Energy accumulator, independent of waveform mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            energy_q <= 40'h00_0000_0000;
        end else if (t1_q) begin
            energy_q <= en_sum;
        end
    end

    // ------------------------------------------------------------
    // Channel 2 wave low-pass
    // ------------------------------------------------------------
    assign lpf_x = $signed({ch2_q, {LPF_FRAC{1'b0}}});

    // One-pole filter at the output rate
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lpf_q <= 28'sh0;
        end else if (t1_q) begin
            lpf_q <= lpf_q + ((lpf_x - lpf_q) >>> LPF_SHIFT);
        end
    end

    // ------------------------------------------------------------
    // Rate selection and waveform register
    // ------------------------------------------------------------
    assign rmask = 3'((4'h1 << rate_q) - 4'h1);
    assign take = (rc_q & rmask) == 3'h0;
    assign wave_load = t2_q && take && ien_q[BIT_SAMPLE];

    // Decimation counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rc_q <= 3'h0;
        end else if (t2_q) begin
            rc_q <= rc_q + 3'h1;
        end
    end

    // Waveform word by source
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wave_q <= 40'h00_0000_0000;
        end else if (wave_load) begin
            case (adwg_src_type'(src_q))
                SRC_BOTH: wave_q <= {ch1_q, ch2_q};
                SRC_CH1: wave_q <= {{20{ch1_q[19]}}, ch1_q};
                SRC_CH2: wave_q <= {{20{lpf_q[27]}}, lpf_q[27:8]};
                SRC_POWER: wave_q <= {{20{pw[39]}}, pw[39:20]};
                default: wave_q <= 40'h00_0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    assign wr = bus_req.write;
    assign rd_acc = bus_req.read && rd_done_q;
    assign waitrequest = bus_req.read && !rd_done_q;
    assign readdata = rdata_q;
    assign nbytes = (src_q == SRC_BOTH) ? 3'h5 : 3'h3;
    assign cur_byte = wave_q[8*(nbytes - 3'h1 - bidx_q) +: 8];
    assign sample_clr = rd_acc && ((bus_req.address == OFS_ISTAT)
        || (bus_req.address == OFS_WAVE_LO)
        || (bus_req.address == OFS_WAVE_BYTE && bidx_q == nbytes - 3'h1));

    // Read mux
    always_comb begin
        rmux = 32'h0000_0000;
        case (bus_req.address)
            OFS_MODE: rmux = {17'h0, src_q, rate_q, 11'h0};
            OFS_IEN: rmux = {28'h0, ien_q};
            OFS_ISTAT: rmux = {28'h0, istat_q};
            OFS_GAIN: rmux = {20'h0, gain_q};
            OFS_PHASE: rmux = {24'h0, phase_q};
            OFS_WAVE_HI: rmux = {24'h0, wave_q[39:32]};
            OFS_WAVE_LO: rmux = wave_q[31:0];
            OFS_WAVE_BYTE: rmux = {24'h0, cur_byte};
            OFS_EN_LO: rmux = energy_q[31:0];
            OFS_EN_HI: rmux = {24'h0, energy_q[39:32]};
            default: rmux = 32'h0000_0000;
        endcase
    end

    // One wait cycle, then read data from flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_done_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rd_done_q <= bus_req.read && !rd_done_q;
            if (bus_req.read && !rd_done_q) begin
                rdata_q <= rmux;
            end
        end
    end

    // Byte readout index, restarted by each new sample
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bidx_q <= 3'h0;
        end else if (wave_load) begin
            bidx_q <= 3'h0;
        end else if (rd_acc && bus_req.address == OFS_WAVE_BYTE) begin
            bidx_q <= (bidx_q == nbytes - 3'h1) ? 3'h0 : bidx_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Byte-lane merged write words, one per register
    assign mode_m = merge({17'h0, src_q, rate_q, 11'h0}, bus_req.writedata, bus_req.byteenable);
    assign ien_m = merge({28'h0, ien_q}, bus_req.writedata, bus_req.byteenable);
    assign gain_m = merge({20'h0, gain_q}, bus_req.writedata, bus_req.byteenable);
    assign phase_m = merge({24'h0, phase_q}, bus_req.writedata, bus_req.byteenable);
    assign ph_new = phase_m[7:0];

    // Mode, enable, gain and phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            src_q <= SRC_RST;
            rate_q <= RATE_RST;
            ien_q <= IEN_RST;
            gain_q <= GAIN_RST;
            phase_q <= PHASE_RST;
        end else if (wr) begin
            case (bus_req.address)
                OFS_MODE: {src_q, rate_q} <= mode_m[14:11];
                OFS_IEN: ien_q <= ien_m[3:0] & IRQ_BITS;
                OFS_GAIN: gain_q <= gain_m[11:0];
                OFS_PHASE: begin
                    if ($signed(ph_new) < $signed(PH_MIN)) begin
                        phase_q <= PH_MIN;
                    end else if ($signed(ph_new) > $signed(PH_MAX)) begin
                        phase_q <= PH_MAX;
                    end else begin
                        phase_q <= ph_new;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            istat_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (i == BIT_SAMPLE && wave_load) begin
                    istat_q[i] <= 1'b1;
                end else if (i == BIT_WRAP && wrap_ev) begin
                    istat_q[i] <= 1'b1;
                end else if (i == BIT_SAMPLE && sample_clr) begin
                    istat_q[i] <= 1'b0;
                end else if (wr && bus_req.address == OFS_ISTAT
                        && bus_req.byteenable[0] && bus_req.writedata[i]) begin
                    istat_q[i] <= 1'b0;
                end
            end
        end
    end

    // Level interrupt while an enabled flag is set
    assign irq = |(istat_q & ien_q);
    assign irq_n = !irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    clamp_range_a: assert property (@(posedge ref_clk) disable iff (rst)
        $signed(ch1_sat) <= $signed(POS_LIMIT) && $signed(ch1_sat) >= $signed(NEG_LIMIT))
        else $error("channel 1 result outside clamp limits");

    mod_period_a: assert property (@(posedge ref_clk) disable iff (rst)
        mod_tick |=> !mod_tick [*3] ##1 mod_tick)
        else $error("modulator tick period is not four clocks");

    out_spacing_a: assert property (@(posedge ref_clk) disable iff (rst)
        out_tick |=> !out_tick [*8])
        else $error("output samples closer than the full rate");

    load_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        wave_load |-> ien_q[BIT_SAMPLE] && $past(out_tick, 2))
        else $error("waveform loaded without enable or tick");

    full_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
        t2_q && rate_q == 2'h0 && ien_q[BIT_SAMPLE] |-> wave_load)
        else $error("full rate skipped a sample");

    irq_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        wave_load |=> istat_q[BIT_SAMPLE] && !irq_n)
        else $error("new sample did not pull the interrupt low");

    both_word_a: assert property (@(posedge ref_clk) disable iff (rst)
        wave_load && src_q == SRC_BOTH |=> wave_q == {$past(ch1_q), $past(ch2_q)})
        else $error("combined word does not hold both channels");

    phase_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        $signed(phase_q) >= $signed(PH_MIN) && $signed(phase_q) <= $signed(PH_MAX))
        else $error("phase value outside its range");

    energy_run_a: assert property (@(posedge ref_clk) disable iff (rst)
        t1_q |=> energy_q == $past(energy_q) + $past(inc))
        else $error("energy accumulation stalled");

    irq_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_acc && bus_req.address == OFS_ISTAT && !wave_load |=> !istat_q[BIT_SAMPLE])
        else $error("status read did not release the sample flag");

    read_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.read && waitrequest |=> !waitrequest)
        else $error("read not answered in one wait cycle");

endmodule // adwg_path
`default_nettype wire

// File: test/adwg_host.sv
// Host bus master model for the waveform gain and phase path registers
`timescale 1ns/1ps
`default_nettype none
module adwg_host (
    input wire logic ref_clk,
    output var adwg_pkg::adwg_bus_req_type bus_req,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    import adwg_pkg::*;
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Idle bus from time zero
    initial begin
        bus_req = '0;
    end
    // One transfer, held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge ref_clk);
        bus_req.address <= a;
        bus_req.read <= rd;
        bus_req.write <= !rd;
        bus_req.writedata <= d;
        bus_req.byteenable <= 4'hF;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
    endtask
    // Select a source and rate, with the sample interrupt enabled
    task automatic arm_wave(input logic [1:0] src, input logic [1:0] rate);
        logic [31:0] q;
        xfer(1'b0, OFS_MODE, (32'(src) << SRC_LSB) | (32'(rate) << RATE_LSB), q);
        xfer(1'b0, OFS_IEN, 32'h8, q);
    endtask
endmodule // adwg_host
`default_nettype wire

// File: test/testbench.sv
// Self-checking testbench of the waveform gain and phase path
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adwg_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    adwg_bus_req_type bus_req;
    logic [31:0] readdata;
    logic waitrequest;
    adwg_raw_type raw = '0;
    logic mod_tick;
    logic irq;
    logic irq_n;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int tk_gap = 0;
    logic tk_seen = 1'b0;
    // ------------------------------------------------------------
    // Clock, instances and monitors
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    adwg_path #(.DEPTH(256)) u_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
        .readdata(readdata), .waitrequest(waitrequest), .raw(raw), .mod_tick(mod_tick),
        .irq(irq), .irq_n(irq_n));
    adwg_host u_host (.ref_clk(ref_clk), .bus_req(bus_req), .readdata(readdata),
        .waitrequest(waitrequest));
    // Modulator tick spacing
    always @(posedge ref_clk) begin
        if (rst) begin
            tk_seen <= 1'b0;
        end else if (mod_tick === 1'b1) begin
            if (tk_seen) chk(40'(tk_gap + 1), 40'd4);
            tk_seen <= 1'b1;
            tk_gap <= 0;
        end else begin
            tk_gap <= tk_gap + 1;
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        u_host.xfer(1'b1, a, 32'h0, q);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (irq_n !== 1'b0 && n < 3000);
        chk(40'(irq_n), 40'h0);
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_count);
    endtask
    // Expected channel 1 value: clamp, scale, sign-extend to 24 bits
    function automatic logic [23:0] exp_ch1(input logic [23:0] r, input logic [11:0] g);
        longint s;
        logic [19:0] v;
        s = longint'($signed(r));
        if (s > 262144) s = 262144;
        if (s < -262144) s = -262144;
        s = (s * (4096 + longint'($signed(g)))) >>> 12;
        v = s[19:0];
        return {{4{v[19]}}, v};
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, unmapped place, reserved bits
    task automatic test_regs();
        logic [31:0] q;
        logic [7:0] ofs [5] = '{OFS_MODE, OFS_IEN, OFS_ISTAT, OFS_GAIN, OFS_PHASE};
        foreach (ofs[i]) begin
            rd(ofs[i], q);
            chk(40'(q), 40'h0);
        end
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, q);
        chk(40'(q), 40'h0);
        wr(OFS_GAIN, 32'hFFFFFABC);
        rd(OFS_GAIN, q);
        chk(40'(q), 40'hABC);
        done("regs");
    endtask
    // Phase value clamped to its usable range
    task automatic test_phase();
        logic [31:0] q;
        logic [7:0] wv [5] = '{8'h80, 8'h7F, 8'hFC, 8'h9E, 8'h5C};
        logic [7:0] ev [5] = '{8'h9E, 8'h5C, 8'hFC, 8'h9E, 8'h5C};
        foreach (wv[i]) begin
            wr(OFS_PHASE, 32'(wv[i]));
            rd(OFS_PHASE, q);
            chk(40'(q), 40'(ev[i]));
        end
        wr(OFS_PHASE, 32'h0);
        done("phase");
    endtask
    // Channel 1 gain and clamping, word and byte readout, interrupt release
    task automatic test_gain();
        logic [31:0] q;
        logic [23:0] e;
        logic [23:0] rv [4] = '{24'h7FFFFF, 24'hF00000, 24'h7FFFFF, 24'h012345};
        logic [11:0] gv [4] = '{12'h000, 12'h000, 12'h7FF, 12'h801};
        u_host.arm_wave(SRC_CH1, 2'b00);
        foreach (rv[i]) begin
            raw.ch1 <= rv[i];
            wr(OFS_GAIN, 32'(gv[i]));
            e = exp_ch1(rv[i], gv[i]);
            wait_irq();
            rd(OFS_WAVE_LO, q);
            wait_irq();
            rd(OFS_WAVE_LO, q);
            chk(40'(q[23:0]), 40'(e));
            repeat (2) @(posedge ref_clk);
            chk(40'(irq_n), 40'h1);
            wait_irq();
            for (int b = 2; b >= 0; b--) begin
                rd(OFS_WAVE_BYTE, q);
                chk(40'(q[7:0]), 40'(e[b*8 +: 8]));
            end
        end
        wr(OFS_GAIN, 32'h0);
        done("gain");
    endtask
    // Combined word layout, byte order, energy keeps running
    task automatic test_both();
        logic [31:0] q;
        logic [31:0] e0;
        logic [7:0] eb [5] = '{8'h12, 8'h34, 8'h5E, 8'hDC, 8'hBA};
        raw.ch1 <= 24'h012345;
        raw.ch2 <= 24'hFEDCBA;
        u_host.arm_wave(SRC_BOTH, 2'b00);
        rd(OFS_EN_LO, e0);
        repeat (6) begin
            wait_irq();
            rd(OFS_WAVE_LO, q);
        end
        rd(OFS_EN_LO, q);
        chk(40'(q != e0), 40'h1);
        wait_irq();
        rd(OFS_WAVE_HI, q);
        chk(40'(q), 40'h12);
        rd(OFS_WAVE_LO, q);
        chk(40'(q), 40'h345EDCBA);
        wait_irq();
        foreach (eb[i]) begin
            rd(OFS_WAVE_BYTE, q);
            chk(40'(q[7:0]), 40'(eb[i]));
        end
        done("both");
    endtask
    // Sample spacing for every rate code, one source each
    task automatic test_rate();
        logic [31:0] q;
        int t1;
        for (int i = 0; i < 4; i++) begin
            u_host.arm_wave(2'(i), 2'(i));
            wait_irq();
            rd(OFS_WAVE_LO, q);
            wait_irq();
            t1 = cyc;
            rd(OFS_WAVE_LO, q);
            wait_irq();
            chk(40'(cyc - t1), 40'(128 << i));
        end
        done("rate");
    endtask
    // Interrupt held off, raised, masked and cleared
    task automatic test_mask();
        logic bad;
        wr(OFS_MODE, 32'h4000);
        wr(OFS_IEN, 32'h0);
        wr(OFS_ISTAT, 32'hC);
        bad = 1'b0;
        repeat (300) begin
            @(posedge ref_clk);
            if (irq_n !== 1'b1) bad = 1'b1;
        end
        chk(40'(bad), 40'h0);
        wr(OFS_IEN, 32'h8);
        wait_irq();
        chk(40'(irq), 40'h1);
        wr(OFS_IEN, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(40'(irq_n), 40'h1);
        wr(OFS_ISTAT, 32'h8);
        wr(OFS_IEN, 32'h8);
        repeat (2) @(posedge ref_clk);
        chk(40'(irq_n), 40'h1);
        done("mask");
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        test_regs();
        test_phase();
        test_gain();
        test_both();
        test_rate();
        test_mask();
        report_and_stop();
    end
    // Run limit about six times the expected length of all scenarios
    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
